// ===== rtl/acc_cfg.svh
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

// opcodes of the two authenticated transactions
`define ACC_SECURE_COMMAND_OPCODE 8'h9B
`define ACC_SECURE_STATUS_READ_OPCODE 8'h96

// subcommand type codes
`define ACC_CT_KEY_REFRESH 8'h01
`define ACC_CT_INCREMENT 8'h02
`define ACC_CT_REQUEST 8'h03

// status byte values and bit positions
`define ACC_ST_POWER_ON 8'h00
`define ACC_ST_SUCCESS 8'h80
`define ACC_ST_BUSY 8'h01
`define ACC_BIT_BUSY 0
`define ACC_BIT_CTR_UNINIT 1
`define ACC_BIT_AUTH 2
`define ACC_BIT_PREV_UNINIT 3
`define ACC_BIT_CTR_MISMATCH 4

// frame lengths in bytes, opcode included
`define ACC_LEN_SHORT_BYTES 10'd40
`define ACC_LEN_REQUEST_BYTES 10'd48
`define ACC_MSG_SHORT_BYTES 10'd8
`define ACC_MSG_REQUEST_BYTES 10'd16

// link timing in bits
`define ACC_OPCODE_BITS 10'd8
`define ACC_DUMMY_BITS 10'd8
`define ACC_STATUS_BITS 10'd8

// hash message lengths in bits
`define ACC_HASH_SEED_BITS 8'd32
`define ACC_HASH_SHORT_BITS 8'd64
`define ACC_HASH_REQUEST_BITS 8'd128

`endif

// ===== rtl/acc_pkg.sv
package acc_pkg;
   // sequencing of one authenticated command after its frame ends
   typedef enum logic [2:0] {
      ACC_IDLE,
      ACC_EVAL,
      ACC_HASH_KEY,
      ACC_HASH_SIG
   } acc_state_t;
endpackage

// ===== rtl/acc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module acc_sync #(
   parameter logic INIT = 1'b0
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   input wire logic din,
   output logic dout
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // three stages; output moves only when stages two and three agree
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         s1_reg <= INIT;
         s2_reg <= INIT;
         s3_reg <= INIT;
         dout <= INIT;
      end
      else if (ce)
      begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg)
         begin
            dout <= s3_reg;
         end
      end
   end
endmodule
`default_nettype wire

// ===== rtl/acc_shift.sv
`timescale 1ns/1ns
`default_nettype none
module acc_shift (
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   input wire logic clear,
   input wire logic bit_stb,
   input wire logic bit_in,
   output logic [7:0] byte_val,
   output logic byte_stb
);
   logic [6:0] part_reg;
   logic [2:0] cnt_reg;

   // msb arrives first, so bits enter at the bottom and move up
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         part_reg <= 7'h00;
         cnt_reg <= 3'h0;
         byte_val <= 8'h00;
         byte_stb <= 1'b0;
      end
      else if (ce)
      begin
         byte_stb <= 1'b0;
         if (clear)
         begin
            cnt_reg <= 3'h0;
         end
         else if (bit_stb)
         begin
            part_reg <= {part_reg[5:0], bit_in};
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == 3'h7)
            begin
               byte_val <= {part_reg, bit_in};
               byte_stb <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== rtl/acc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "acc_cfg.svh"

module acc_top
   import acc_pkg::*;
#(
   parameter int NUM_SLOTS = 4
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   output logic so,
   output logic so_oe,
   input wire logic [NUM_SLOTS-1:0] ctr_valid_strap,
   input wire logic [NUM_SLOTS*256-1:0] root_key_flat,
   output logic hash_start,
   output logic [255:0] hash_key,
   output logic [127:0] hash_msg,
   output logic [7:0] hash_msg_bits,
   input wire logic hash_done,
   input wire logic [255:0] hash_digest,
   output logic [7:0] authenticated_op_status,
   output logic busy,
   output logic [31:0] readout_counter
);
   import acc_pkg::*;

   localparam int SW = (NUM_SLOTS > 1) ? $clog2(NUM_SLOTS) : 1;

   // the status byte and slot field are bytes, so more than 256 slots are unusable
   // refused while elaborating, before any storage is sized from it
   if (NUM_SLOTS < 1 || NUM_SLOTS > 256)
   begin : g_bad_slots
      $error("acc_top: NUM_SLOTS must lie in 1..256");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // link sampling

   logic sclk_f;
   logic cs_n_f;
   logic si_f;
   logic sclk_d_reg;
   logic cs_n_d_reg;
   logic rise;
   logic fall;
   logic frame_end;
   logic [7:0] byte_val;
   logic byte_stb;

   acc_sync #(.INIT(1'b0)) u_sync_sclk (
      .mclk(mclk), .srst(srst), .ce(ce), .din(sclk), .dout(sclk_f)
   );
   acc_sync #(.INIT(1'b1)) u_sync_cs (
      .mclk(mclk), .srst(srst), .ce(ce), .din(cs_n), .dout(cs_n_f)
   );
   acc_sync #(.INIT(1'b0)) u_sync_si (
      .mclk(mclk), .srst(srst), .ce(ce), .din(si), .dout(si_f)
   );

   // edge finding on the filtered levels
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         sclk_d_reg <= 1'b0;
         cs_n_d_reg <= 1'b1;
      end
      else if (ce)
      begin
         sclk_d_reg <= sclk_f;
         cs_n_d_reg <= cs_n_f;
      end
   end

   assign rise = sclk_f & ~sclk_d_reg & ~cs_n_f;
   assign fall = ~sclk_f & sclk_d_reg & ~cs_n_f;
   assign frame_end = cs_n_f & ~cs_n_d_reg;

   acc_shift u_shift (
      .mclk(mclk),
      .srst(srst),
      .ce(ce),
      .clear(cs_n_f),
      .bit_stb(rise),
      .bit_in(si_f),
      .byte_val(byte_val),
      .byte_stb(byte_stb)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // frame capture

   acc_state_t state_reg;
   logic [9:0] bit_cnt_reg;
   logic [9:0] byte_cnt_reg;
   logic sec_frame_reg;
   logic rd_frame_reg;
   logic [7:0] ctype_reg;
   logic [7:0] slot_reg;
   logic [127:0] msg_reg;
   logic [255:0] sig_reg;
   logic [9:0] frame_bits_reg;
   logic [9:0] msg_bytes;

   // type byte decides how many bytes belong to the message
   assign msg_bytes = (ctype_reg == `ACC_CT_REQUEST) ? `ACC_MSG_REQUEST_BYTES
                                                    : `ACC_MSG_SHORT_BYTES;

   // bit and byte counts saturate so long frames cannot wrap into a valid size
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         bit_cnt_reg <= 10'd0;
         byte_cnt_reg <= 10'd0;
      end
      else if (ce)
      begin
         if (cs_n_f)
         begin
            bit_cnt_reg <= 10'd0;
            byte_cnt_reg <= 10'd0;
         end
         else
         begin
            if (rise && bit_cnt_reg != 10'h3FF)
            begin
               bit_cnt_reg <= bit_cnt_reg + 10'd1;
            end
            if (byte_stb && byte_cnt_reg != 10'h3FF)
            begin
               byte_cnt_reg <= byte_cnt_reg + 10'd1;
            end
         end
      end
   end

   // opcode decode; a command frame while busy is not taken
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         sec_frame_reg <= 1'b0;
         rd_frame_reg <= 1'b0;
         frame_bits_reg <= 10'd0;
      end
      else if (ce)
      begin
         if (frame_end)
         begin
            sec_frame_reg <= 1'b0;
            rd_frame_reg <= 1'b0;
            frame_bits_reg <= bit_cnt_reg;
         end
         else if (byte_stb && byte_cnt_reg == 10'd0)
         begin
            sec_frame_reg <= (byte_val == `ACC_SECURE_COMMAND_OPCODE) &&
                             (state_reg == ACC_IDLE);
            rd_frame_reg <= (byte_val == `ACC_SECURE_STATUS_READ_OPCODE);
         end
      end
   end

   // message bytes, then signature bytes, both msb first
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         ctype_reg <= 8'h00;
         slot_reg <= 8'h00;
         msg_reg <= 128'h0;
         sig_reg <= 256'h0;
      end
      else if (ce && byte_stb && state_reg == ACC_IDLE)
      begin
         if (byte_cnt_reg == 10'd0)
         begin
            ctype_reg <= 8'h00;
         end
         if (byte_cnt_reg == 10'd1)
         begin
            ctype_reg <= byte_val;
         end
         if (byte_cnt_reg == 10'd2)
         begin
            slot_reg <= byte_val;
         end
         if (byte_cnt_reg < msg_bytes)
         begin
            msg_reg <= {msg_reg[119:0], byte_val};
         end
         else
         begin
            sig_reg <= {sig_reg[247:0], byte_val};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // slot storage

   logic [255:0] session_key_store [NUM_SLOTS];
   logic [NUM_SLOTS-1:0] key_valid_reg;
   logic [31:0] counter_reg [NUM_SLOTS];
   logic [NUM_SLOTS-1:0] ctr_valid_reg;
   logic strap_pend_reg;
   logic [255:0] derived_key_scratch;
   logic [SW-1:0] sidx;
   logic slot_ok;
   logic fin;
   logic fin_ok;
   logic [7:0] fin_code;

   assign sidx = slot_reg[SW-1:0];
   assign slot_ok = ({24'h0, slot_reg} < NUM_SLOTS);

   // keys live in flip-flops and reset clears them
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         key_valid_reg <= '0;
         for (int i = 0; i < NUM_SLOTS; i++)
         begin
            session_key_store[i] <= 256'h0;
         end
      end
      else if (ce && fin && fin_ok && ctype_reg == `ACC_CT_KEY_REFRESH)
      begin
         session_key_store[sidx] <= derived_key_scratch;
         key_valid_reg[sidx] <= 1'b1;
      end
   end

   // counter validity straps are caught on the first enabled cycle after reset
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         strap_pend_reg <= 1'b1;
         ctr_valid_reg <= '0;
      end
      else if (ce && strap_pend_reg)
      begin
         strap_pend_reg <= 1'b0;
         ctr_valid_reg <= ctr_valid_strap;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         for (int i = 0; i < NUM_SLOTS; i++)
         begin
            counter_reg[i] <= 32'h0;
         end
      end
      else if (ce && fin && fin_ok && ctype_reg == `ACC_CT_INCREMENT)
      begin
         counter_reg[sidx] <= counter_reg[sidx] + 32'h1;
      end
   end

   // request copies the counter for the later readout
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         readout_counter <= 32'h0;
      end
      else if (ce && fin && fin_ok && ctype_reg == `ACC_CT_REQUEST)
      begin
         readout_counter <= counter_reg[sidx];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // command sequencing

   logic size_ok;
   logic [9:0] want_bytes;

   assign want_bytes = (ctype_reg == `ACC_CT_REQUEST) ? `ACC_LEN_REQUEST_BYTES
                                                     : `ACC_LEN_SHORT_BYTES;
   assign size_ok = (frame_bits_reg == {want_bytes[6:0], 3'b000});

   // outcome of the current step; errors never reach storage
   always_comb
   begin
      fin = 1'b0;
      fin_ok = 1'b0;
      fin_code = `ACC_ST_SUCCESS;
      if (state_reg == ACC_EVAL)
      begin
         fin_code = `ACC_ST_POWER_ON;
         if (!size_ok || ctype_reg < `ACC_CT_KEY_REFRESH ||
             ctype_reg > `ACC_CT_REQUEST || !slot_ok)
         begin
            fin = 1'b1;
            fin_code[`ACC_BIT_AUTH] = 1'b1;
         end
         else if (ctype_reg == `ACC_CT_KEY_REFRESH && !ctr_valid_reg[sidx])
         begin
            fin = 1'b1;
            fin_code[`ACC_BIT_CTR_UNINIT] = 1'b1;
         end
         else if (ctype_reg != `ACC_CT_KEY_REFRESH &&
                  (!key_valid_reg[sidx] || !ctr_valid_reg[sidx]))
         begin
            fin = 1'b1;
            fin_code[`ACC_BIT_PREV_UNINIT] = 1'b1;
         end
      end
      else if (state_reg == ACC_HASH_SIG && hash_done)
      begin
         fin = 1'b1;
         fin_code = `ACC_ST_POWER_ON;
         if (hash_digest != sig_reg)
         begin
            fin_code[`ACC_BIT_AUTH] = 1'b1;
         end
         if (ctype_reg == `ACC_CT_INCREMENT && msg_reg[31:0] != counter_reg[sidx])
         begin
            fin_code[`ACC_BIT_CTR_MISMATCH] = 1'b1;
         end
         if (fin_code == `ACC_ST_POWER_ON)
         begin
            fin_ok = 1'b1;
            fin_code = `ACC_ST_SUCCESS;
         end
      end
   end

   // hash requests go to the shared core; one outstanding at a time
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         state_reg <= ACC_IDLE;
         hash_start <= 1'b0;
         hash_key <= 256'h0;
         hash_msg <= 128'h0;
         hash_msg_bits <= 8'h00;
         derived_key_scratch <= 256'h0;
      end
      else if (ce)
      begin
         hash_start <= 1'b0;
         case (state_reg)
            ACC_IDLE:
            begin
               if (frame_end && sec_frame_reg)
               begin
                  state_reg <= ACC_EVAL;
               end
            end
            ACC_EVAL:
            begin
               if (fin)
               begin
                  state_reg <= ACC_IDLE;
               end
               else if (ctype_reg == `ACC_CT_KEY_REFRESH)
               begin
                  // seed keyed with the slot root secret
                  hash_start <= 1'b1;
                  hash_key <= root_key_flat[sidx*256 +: 256];
                  hash_msg <= {96'h0, msg_reg[31:0]};
                  hash_msg_bits <= `ACC_HASH_SEED_BITS;
                  state_reg <= ACC_HASH_KEY;
               end
               else
               begin
                  // signature keyed with the session key
                  hash_start <= 1'b1;
                  hash_key <= session_key_store[sidx];
                  hash_msg <= (ctype_reg == `ACC_CT_REQUEST) ? msg_reg
                                                             : {64'h0, msg_reg[63:0]};
                  hash_msg_bits <= (ctype_reg == `ACC_CT_REQUEST) ?
                                   `ACC_HASH_REQUEST_BITS : `ACC_HASH_SHORT_BITS;
                  state_reg <= ACC_HASH_SIG;
               end
            end
            ACC_HASH_KEY:
            begin
               if (hash_done)
               begin
                  // derived key signs the 64-bit message
                  derived_key_scratch <= hash_digest;
                  hash_start <= 1'b1;
                  hash_key <= hash_digest;
                  hash_msg <= {64'h0, msg_reg[63:0]};
                  hash_msg_bits <= `ACC_HASH_SHORT_BITS;
                  state_reg <= ACC_HASH_SIG;
               end
            end
            ACC_HASH_SIG:
            begin
               if (hash_done)
               begin
                  state_reg <= ACC_IDLE;
               end
            end
            default:
            begin
               state_reg <= ACC_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status byte and readout

   // nothing changes before the opcode byte is complete
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         authenticated_op_status <= `ACC_ST_POWER_ON;
      end
      else if (ce)
      begin
         if (fin)
         begin
            authenticated_op_status <= fin_code;
         end
         else if (byte_stb && byte_cnt_reg == 10'd0 && state_reg == ACC_IDLE &&
                  byte_val == `ACC_SECURE_COMMAND_OPCODE)
         begin
            authenticated_op_status <= `ACC_ST_BUSY;
         end
      end
   end

   assign busy = authenticated_op_status[`ACC_BIT_BUSY];

   // status leaves on falling edges after opcode and dummy bits
   // the counter payload after the status byte is not served here; zeros go out
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         so <= 1'b0;
         so_oe <= 1'b0;
      end
      else if (ce)
      begin
         if (cs_n_f || !rd_frame_reg)
         begin
            so <= 1'b0;
            so_oe <= 1'b0;
         end
         else if (fall && bit_cnt_reg >= `ACC_OPCODE_BITS + `ACC_DUMMY_BITS)
         begin
            so_oe <= 1'b1;
            if (bit_cnt_reg < `ACC_OPCODE_BITS + `ACC_DUMMY_BITS + `ACC_STATUS_BITS)
            begin
               so <= authenticated_op_status[3'(10'd23 - bit_cnt_reg)];
            end
            else
            begin
               so <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/acc_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module acc_top_properties #(
   parameter int NUM_SLOTS = 4
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic cs_n,
   input wire logic so_oe,
   input wire logic hash_start,
   input wire logic [255:0] hash_key,
   input wire logic [7:0] hash_msg_bits,
   input wire logic hash_done,
   input wire logic [255:0] hash_digest,
   input wire logic [7:0] authenticated_op_status,
   input wire logic busy,
   input wire logic [31:0] readout_counter
);
   logic seed_pend_reg;
   logic [255:0] dig_reg;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // seed hash pending, so the next 64-bit hash must use its digest
   always_ff @(posedge mclk)
   begin
      if (srst)
         seed_pend_reg <= 1'b0;
      else if (hash_start)
         seed_pend_reg <= hash_msg_bits == 8'd32;
   end
   // last digest, held for the chained key check
   always_ff @(posedge mclk)
   begin
      if (srst)
         dig_reg <= '0;
      else if (hash_done)
         dig_reg <= hash_digest;
   end
   sequence s_result;
      hash_done && busy && hash_msg_bits != 8'd32;
   endsequence
   sequence s_key_hash;
      hash_start && hash_msg_bits == 8'd64 && seed_pend_reg;
   endsequence
   ////////////////////////////////////////
   // busy mirrors bit
   a_busy_mirror: assert property (busy == authenticated_op_status[0] &&
      (!busy || authenticated_op_status == 8'h01))
      else $error("busy flag or busy code wrong");
   a_busy_rise: assert property ($rose(busy) |-> authenticated_op_status == 8'h01)
      else $error("busy entry code wrong");
   a_success_exact: assert property (authenticated_op_status[7] |-> authenticated_op_status == 8'h80)
      else $error("success code mixed with other bits");
   a_status_via_busy: assert property ($changed(authenticated_op_status) |-> busy || $past(busy))
      else $error("status changed outside a command");
   a_hash_in_busy: assert property (hash_start |-> busy)
      else $error("hash request while idle");
   a_msg_len: assert property (hash_start |-> hash_msg_bits inside {8'd32, 8'd64, 8'd128})
      else $error("bad hash message length");
   a_derived_key: assert property (s_key_hash |-> hash_key == dig_reg)
      else $error("refresh signature not keyed by derived key");
   a_result_prompt: assert property (s_result |-> ##[1:2] !busy)
      else $error("busy not cleared after final digest");
   a_readout_ok: assert property ($changed(readout_counter) |-> authenticated_op_status == 8'h80)
      else $error("readout changed without success");
   a_oe_release: assert property (cs_n [*8] |-> !so_oe)
      else $error("so driven while deselected");
endmodule
bind acc_top acc_top_properties #(.NUM_SLOTS(NUM_SLOTS)) prop_u (
   .mclk(mclk), .srst(srst), .cs_n(cs_n), .so_oe(so_oe), .hash_start(hash_start),
   .hash_key(hash_key), .hash_msg_bits(hash_msg_bits), .hash_done(hash_done),
   .hash_digest(hash_digest), .authenticated_op_status(authenticated_op_status),
   .busy(busy), .readout_counter(readout_counter)
);
`default_nettype wire

// ===== tb/acc_spi_host.sv
`timescale 1ns/1ns
`default_nettype none
module acc_spi_host (
   output logic sclk,
   output logic cs_n,
   output logic si,
   input wire logic so,
   input wire logic so_oe
);
   // idle link: clock parked low, deselected
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   // msb first, bytes in queue order
   task automatic xfer(input logic [7:0] q[$], input int nbits, output logic [7:0] rd);
      rd = 8'h00;
      cs_n = 1'b0;
      #63;
      for (int i = 0; i < nbits; i++)
      begin
         si = q[i / 8][7 - i % 8];
         #62 sclk = 1'b1;
         // status after dummy byte; undriven line reads unknown
         if (i >= 16 && i < 24)
            rd = {rd[6:0], so_oe ? so : 1'bx};
         #63 sclk = 1'b0;
      end
      #62 cs_n = 1'b1;
      si = ~si; // released line must not keep the last bit
      #500;
   endtask
endmodule
`default_nettype wire

// ===== tb/acc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "acc_cfg.svh"
module acc_top_tb;
   logic mclk, srst, ce, sclk, cs_n, si, so, so_oe, hash_start, hash_done, busy, hbig;
   logic [3:0] ctr_valid_strap, kv;
   logic [1023:0] root_key_flat;
   logic [255:0] hash_key, hash_digest;
   logic [255:0] skey [4];
   logic [127:0] hash_msg;
   logic [7:0] hash_msg_bits, authenticated_op_status, st, exp_st;
   logic [31:0] readout_counter;
   logic [31:0] ctr [4];
   int err_total = 0;
   int checks_done = 0;
   int hcnt = 0;
   acc_top #(.NUM_SLOTS(4)) dut_u (
      .mclk(mclk), .srst(srst), .ce(ce), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
      .so_oe(so_oe), .ctr_valid_strap(ctr_valid_strap), .root_key_flat(root_key_flat),
      .hash_start(hash_start), .hash_key(hash_key), .hash_msg(hash_msg),
      .hash_msg_bits(hash_msg_bits), .hash_done(hash_done), .hash_digest(hash_digest),
      .authenticated_op_status(authenticated_op_status), .busy(busy),
      .readout_counter(readout_counter)
   );
   acc_spi_host host_u (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   ////////////////////////////////////////
   // stand-in hash: a cheap keyed mix, enough to tell keys and messages apart
   function automatic logic [255:0] hfn(input logic [255:0] k, input logic [127:0] m,
                                        input logic [7:0] b);
      logic [127:0] mk;
      mk = (b == 8'd128) ? '1 : (128'h1 << b) - 128'h1;
      hfn = {k[223:0], k[255:224]} ^ {128'h0, m & mk} ^ {b, 248'h0};
   endfunction
   // hash core model; slow mode holds the device busy, digest garbage between answers
   always @(posedge mclk)
   begin
      hash_done <= 1'b0;
      hash_digest <= ~hash_digest;
      if (hash_start)
         hcnt <= hbig ? 6000 : 1 + $urandom % 4;
      else if (hcnt > 0)
         hcnt <= hcnt - 1;
      if (!hash_start && hcnt == 1)
      begin
         hash_done <= 1'b1;
         hash_digest <= hfn(hash_key, hash_msg, hash_msg_bits);
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic rd_st(input int polls);
      logic [7:0] q[$];
      q = {`ACC_SECURE_STATUS_READ_OPCODE, 8'h00, 8'h00};
      for (int i = 0; i < polls; i++)
      begin
         host_u.xfer(q, 24, st);
         if (st[0] !== 1'b1)
            break;
      end
   endtask
   // one command frame; the model state follows the expected outcome
   task automatic op(input logic [7:0] t, input logic [7:0] s, input logic [95:0] pay,
                     input logic bad, input int drop, input int polls);
      logic [7:0] q[$];
      logic [127:0] m;
      logic [255:0] k, sig;
      logic [7:0] e;
      int nb;
      nb = (t == `ACC_CT_REQUEST) ? 16 : 8;
      m = {8'h9B, t, s, 8'h00, pay};
      if (nb == 8)
         m = {64'h0, 8'h9B, t, s, 8'h00, pay[31:0]};
      k = skey[s[1:0]];
      if (t == `ACC_CT_KEY_REFRESH)
         k = hfn(root_key_flat[s[1:0] * 256 +: 256], {96'h0, pay[31:0]}, 8'd32);
      sig = hfn(k, m, (nb == 16) ? 8'd128 : 8'd64) ^ {255'h0, bad};
      e = {3'h0, t == 8'h02 && pay[31:0] != ctr[s[1:0]], 1'b0, bad, 2'h0};
      if (drop != 0 || s > 8'h03 || !(t inside {8'h01, 8'h02, 8'h03}))
         e = 8'h04;
      else if (t == 8'h01 && !ctr_valid_strap[s[1:0]])
         e = 8'h02;
      else if (t != 8'h01 && !(kv[s[1:0]] && ctr_valid_strap[s[1:0]]))
         e = 8'h08;
      exp_st = (e == 8'h00) ? `ACC_ST_SUCCESS : e;
      if (e == 8'h00 && t == 8'h01)
      begin
         skey[s[1:0]] = k;
         kv[s[1:0]] = 1'b1;
      end
      if (e == 8'h00 && t == 8'h02)
         ctr[s[1:0]] = ctr[s[1:0]] + 32'h1;
      for (int i = nb - 1; i >= 0; i--)
         q.push_back(m[i * 8 +: 8]);
      for (int i = 31; i >= 0; i--)
         q.push_back(sig[i * 8 +: 8]);
      for (int i = 0; i < drop; i++)
         void'(q.pop_back());
      host_u.xfer(q, q.size() * 8, st);
      if (polls > 0)
      begin
         rd_st(polls);
         chk(st, exp_st);
         if (t == 8'h03 && e == 8'h00)
            chk(readout_counter, ctr[s[1:0]]);
         $display("test type %h slot %h done", t, s);
      end
   endtask
   ////////////////////////////////////////
   initial
   begin
      logic [7:0] qq[$];
      void'($urandom(32'hD877FB69));
      ce = 1'b1;
      srst = 1'b1;
      hbig = 1'b0;
      ctr_valid_strap = 4'h7;
      kv = 4'h0;
      ctr = '{default: 32'h0};
      skey = '{default: 256'h0};
      for (int i = 0; i < 32; i++)
         root_key_flat[i * 32 +: 32] = $urandom;
      repeat (2) @(posedge mclk);
      #1 srst = 1'b0;
      repeat (8) @(posedge mclk);
      rd_st(1);
      chk(st, `ACC_ST_POWER_ON);
      qq = {`ACC_SECURE_COMMAND_OPCODE};
      host_u.xfer(qq, 7, st);
      rd_st(1);
      chk(st, `ACC_ST_POWER_ON);
      $display("test short frame done");
      op(8'h02, 8'h00, 96'h0, 1'b0, 0, 100);
      op(8'h01, 8'h03, {64'h0, $urandom}, 1'b0, 0, 100);
      hbig = 1'b1;
      op(8'h01, 8'h00, {64'h0, $urandom}, 1'b0, 0, 0);
      rd_st(1);
      chk(st, `ACC_ST_BUSY);
      qq = {};
      repeat (40) qq.push_back(`ACC_SECURE_COMMAND_OPCODE);
      host_u.xfer(qq, 320, st);
      hbig = 1'b0;
      rd_st(100);
      chk(st, exp_st);
      $display("test busy refusal done");
      op(8'h01, 8'h01, {64'h0, $urandom}, 1'b1, 0, 100);
      op(8'h01, 8'h01, {64'h0, $urandom}, 1'b0, 0, 100);
      // counter value field carries the stored count
      repeat (2) op(8'h02, 8'h00, {64'h0, ctr[0]}, 1'b0, 0, 100);
      op(8'h02, 8'h00, {64'h0, ctr[0] + 32'(1 + $urandom % 9)}, 1'b0, 0, 100);
      op(8'h02, 8'h01, {64'h0, ctr[1]}, 1'b0, 1, 100);
      op(8'h03, 8'h00, {$urandom, $urandom, $urandom}, 1'b0, 0, 100);
      op(8'h02, 8'(4 + $urandom % 252), 96'h0, 1'b0, 0, 100);
      for (int i = 0; i < 2; i++)
         op((i == 0) ? 8'h00 : 8'(4 + $urandom % 252), 8'h00, 96'h0, 1'b0, 0, 100);
      op(8'h03, 8'h02, {$urandom, $urandom, $urandom}, 1'b0, 0, 100);
      // second reset: session keys and counts are volatile
      @(posedge mclk);
      #1 srst = 1'b1;
      repeat (2) @(posedge mclk);
      #1 srst = 1'b0;
      kv = 4'h0;
      ctr = '{default: 32'h0};
      repeat (8) @(posedge mclk);
      rd_st(1);
      chk(st, `ACC_ST_POWER_ON);
      op(8'h02, 8'h01, 96'h0, 1'b0, 0, 100);
      end_sim;
   end
   // hang guard, about a third above the expected run
   initial
   begin
      #1000000;
      err_total++;
      end_sim;
   end
endmodule
`default_nettype wire
